//--- keypad_wake_interrupt.sv
// keypad wake interrupt unit: eight key inputs, request latch, apb registers
`timescale 1ns/100ps
`include "kwu_params.svh"
module keypad_wake_interrupt
  import kwu_pkg::*;
#(
  parameter int NUM_KEYS = 8
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // apb slave
  input  wire apb_req_type         apb_req,
  output apb_rsp_type              apb_rsp,
  // keypad pins
  input  wire logic [NUM_KEYS-1:0] keypad_inputs,
  output logic      [NUM_KEYS-1:0] pullup_en,
  output logic      [NUM_KEYS-1:0] force_input,
  // processor side
  input  wire logic                vector_fetch,
  input  wire logic                break_state,
  output logic                     cpu_request,
  output logic                     wake_request,
  output logic      [15:0]         vector_hi_addr,
  output logic      [15:0]         vector_lo_addr,
  // event interrupt
  output logic                     irq
);

  // =====================================================
  // elaboration check
  // the register holds eight enable bits, so more keys cannot be mapped
  if (NUM_KEYS < 1 || NUM_KEYS > 8) begin : g_bad_keys
    $error("NUM_KEYS must lie between 1 and 8");
  end

  // =====================================================
  // functions

  // compare the word address of a bus request with a register index
  function automatic logic hits(input logic [11:0] addr, input logic [7:0] idx);
    hits = (addr[11:2] == {2'h0, idx}) && (addr[1:0] == 2'h0);
  endfunction : hits

  // widen an eight-bit register image onto the data bus
  function automatic logic [31:0] widen(input logic [7:0] val);
    widen = {24'h0, val};
  endfunction : widen

  // =====================================================
  // register state
  logic                level_sense;     // falling edge plus low level mode
  logic                request_mask;    // blocks the request to the core
  logic [7:0]          pin_enable_bits; // one enable per input
  logic                break_clear_enable; // lets ack act in break state
  logic [1:0]          event_status;    // sticky events, write one clears
  logic [1:0]          event_mask;      // events allowed onto irq

  // request latch state
  logic                request_latch;   // the shared keypad request
  logic                ack_seen;        // ack taken while inputs still low
  logic                prev_any_low;    // any enabled input low last cycle

  // apb answer state
  logic                pready_q;        // answers after one wait
  logic                pslverr_q;       // unmapped address
  logic [31:0]         prdata_q;        // captured read data

  // =====================================================
  // synchronised key levels
  logic [NUM_KEYS-1:0] key_level;       // filtered pin levels

  key_sync #(
    .WIDTH     (NUM_KEYS)
  ) u_key_sync (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .pin_raw   (keypad_inputs),
    .pin_level (key_level)
  );

  // =====================================================
  // bus decode
  wire bus_access  = apb_req.psel & apb_req.penable;
  wire bus_done    = bus_access & pready_q;          // edge the master samples
  wire bus_write   = bus_done & apb_req.pwrite;
  wire hit_status  = hits(apb_req.paddr, `KWU_IDX_STATUS_CONTROL);
  wire hit_enable  = hits(apb_req.paddr, `KWU_IDX_PIN_ENABLE);
  wire hit_break   = hits(apb_req.paddr, `KWU_IDX_BREAK_CONTROL);
  wire hit_evstat  = hits(apb_req.paddr, `KWU_IDX_EVENT_STATUS);
  wire hit_evmask  = hits(apb_req.paddr, `KWU_IDX_EVENT_MASK);
  wire hit_any     = hit_status | hit_enable | hit_break | hit_evstat | hit_evmask;

  // write strobes per register
  wire wr_status   = bus_write & hit_status;
  wire wr_enable   = bus_write & hit_enable;
  wire wr_break    = bus_write & hit_break;
  wire wr_evstat   = bus_write & hit_evstat;
  wire wr_evmask   = bus_write & hit_evmask;
  wire [7:0] wbyte = apb_req.pwdata[7:0];
  // reset image of status/control, so each field takes its own bit
  wire [7:0] sc_reset_image = `KWU_RST_STATUS_CONTROL;

  // =====================================================
  // key activity
  wire [NUM_KEYS-1:0] enables  = pin_enable_bits[NUM_KEYS-1:0];
  wire [NUM_KEYS-1:0] low_keys = enables & ~key_level;  // disabled pins ignored
  wire any_low     = |low_keys;
  // a fall counts only when every enabled input was high before,
  // so a second key going down while one is held is not a new edge
  wire new_fall    = any_low & ~prev_any_low;

  // =====================================================
  // acknowledge sources
  wire sw_ack_write = wr_status & wbyte[`KWU_BIT_ACK_STROBE];
  // in break state the strobe is honoured only with break_clear_enable
  wire sw_ack      = sw_ack_write & (~break_state | break_clear_enable);
  wire ack_blocked = sw_ack_write & break_state & ~break_clear_enable;
  wire any_ack     = sw_ack | vector_fetch;

  // =====================================================
  // latch next value
  // edge mode: an ack clears at once whatever the levels
  wire clear_edge  = any_ack;
  // level mode: needs an ack (now or earlier) and all enabled inputs high
  wire clear_level = (any_ack | ack_seen) & ~any_low;
  wire do_clear    = level_sense ? clear_level : clear_edge;
  // a new fall wins over a clear in the same cycle, so an edge right
  // after an ack write is never lost
  wire next_latch  = new_fall | (request_latch & ~do_clear);
  // remember an ack that arrived while inputs were still low
  wire next_ack_seen = level_sense & next_latch & ~new_fall &
                       (ack_seen | any_ack);

  // =====================================================
  // interrupt events
  wire [1:0] ev_set;
  assign ev_set[`KWU_BIT_EV_LATCHED]     = new_fall & ~request_latch;
  assign ev_set[`KWU_BIT_EV_ACK_BLOCKED] = ack_blocked;
  // set wins over the write-one clear
  wire [1:0] next_events = ev_set |
                           (event_status & ~(wr_evstat ? wbyte[1:0] : 2'h0));

  // =====================================================
  // read mux
  wire [7:0] status_image =
    {4'h0, request_latch, 1'b0, request_mask, level_sense};
  wire [31:0] read_word =
    hit_status ? widen(status_image) :
    hit_enable ? widen(pin_enable_bits) :
    hit_break  ? widen({7'h0, break_clear_enable}) :
    hit_evstat ? widen({6'h00, event_status}) :
    hit_evmask ? widen({6'h00, event_mask}) : 32'h0000_0000;

  // =====================================================
  // control registers; reset clears mode, mask and enables
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      level_sense     <= sc_reset_image[`KWU_BIT_LEVEL_SENSE];
      request_mask    <= sc_reset_image[`KWU_BIT_REQUEST_MASK];
      pin_enable_bits <= `KWU_RST_PIN_ENABLE;
    end else begin
      if (wr_status) begin
        level_sense  <= wbyte[`KWU_BIT_LEVEL_SENSE];
        request_mask <= wbyte[`KWU_BIT_REQUEST_MASK];
      end
      if (wr_enable) begin
        pin_enable_bits <= wbyte;
      end
    end
  end

  // =====================================================
  // break and event registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      break_clear_enable <= `KWU_RST_BREAK_CONTROL;      // defaults to protect
      event_status       <= `KWU_RST_EVENTS;
      event_mask         <= `KWU_RST_EVENTS;
    end else begin
      if (wr_break) begin
        break_clear_enable <= wbyte[`KWU_BIT_BREAK_CLEAR];
      end
      if (wr_evmask) begin
        event_mask <= wbyte[1:0];
      end
      event_status <= next_events;
    end
  end

  // =====================================================
  // request latch; reset clears it even while a key is held
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      request_latch <= 1'b0;
      ack_seen      <= 1'b0;
      prev_any_low  <= 1'b0;
    end else begin
      request_latch <= next_latch;
      ack_seen      <= next_ack_seen;
      prev_any_low  <= any_low;
    end
  end

  // =====================================================
  // apb answer: one wait cycle, then pready with captured data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (bus_access & ~pready_q) begin
      // first access cycle: prepare the answer
      pready_q  <= 1'b1;
      pslverr_q <= ~hit_any;
      prdata_q  <= apb_req.pwrite ? 32'h0000_0000 : read_word;
    end else begin
      // answer stands for one cycle only
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
  end

  // =====================================================
  // pin controls: pull-up and direction override follow the enables
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pullup_en   <= '0;
      force_input <= '0;
    end else begin
      pullup_en   <= enables;
      force_input <= enables;
    end
  end

  // =====================================================
  // processor side outputs
  // the request runs on the bus clock without gating, so it still
  // reaches the core while it sleeps in wait or stop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cpu_request    <= 1'b0;
      wake_request   <= 1'b0;
      vector_hi_addr <= `KWU_VECTOR_HI;
      vector_lo_addr <= `KWU_VECTOR_LO;
      irq            <= 1'b0;
    end else begin
      cpu_request    <= next_latch & ~request_mask;
      wake_request   <= next_latch & ~request_mask;
      vector_hi_addr <= `KWU_VECTOR_HI;
      vector_lo_addr <= `KWU_VECTOR_LO;
      irq            <= |(next_events & event_mask);
    end
  end

  // =====================================================
  // bundle the answer
  assign apb_rsp.pready  = pready_q;
  assign apb_rsp.pslverr = pslverr_q;
  assign apb_rsp.prdata  = prdata_q;

endmodule : keypad_wake_interrupt

//--- kwu_params.svh
// keypad wake interrupt offsets, field positions, reset values and timing
`ifndef KWU_PARAMS_SVH
`define KWU_PARAMS_SVH

// =====================================================
// register indexes, byte address is four times these
`define KWU_IDX_STATUS_CONTROL 8'h1A
`define KWU_IDX_PIN_ENABLE     8'h1B
`define KWU_IDX_BREAK_CONTROL  8'h1C
`define KWU_IDX_EVENT_STATUS   8'h1D
`define KWU_IDX_EVENT_MASK     8'h1E

// =====================================================
// status/control field positions
`define KWU_BIT_LEVEL_SENSE    0
`define KWU_BIT_REQUEST_MASK   1
`define KWU_BIT_ACK_STROBE     2
`define KWU_BIT_PENDING_FLAG   3

// break control and event field positions
`define KWU_BIT_BREAK_CLEAR    0
`define KWU_BIT_EV_LATCHED     0
`define KWU_BIT_EV_ACK_BLOCKED 1

// =====================================================
// reset values
`define KWU_RST_STATUS_CONTROL 8'h00
`define KWU_RST_PIN_ENABLE     8'h00
`define KWU_RST_BREAK_CONTROL  1'h0
`define KWU_RST_EVENTS         2'h0

// keypad handler vector pair
`define KWU_VECTOR_HI          16'hFFE0
`define KWU_VECTOR_LO          16'hFFE1

// apb answer delay: one wait cycle in the access phase
`define KWU_APB_WAIT_CYCLES    1

`endif

//--- kwu_pkg.sv
// keypad wake interrupt shared types
package kwu_pkg;

  // =====================================================
  // apb request carried as one bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  // apb answer bundle
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;

endpackage : kwu_pkg

//--- key_sync.sv
// three-stage synchroniser with agreement filter for keypad pins
`timescale 1ns/100ps
module key_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // raw pins and filtered levels
  input  wire logic [WIDTH-1:0] pin_raw,
  output logic      [WIDTH-1:0] pin_level
);

  // =====================================================
  // stages
  logic [WIDTH-1:0] stage1;  // metastable stage, read only by stage2
  logic [WIDTH-1:0] stage2;  // settled
  logic [WIDTH-1:0] stage3;  // one cycle older
  wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);  // stages match per bit

  // =====================================================
  // shift chain; idle keys read high so reset to ones
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage1 <= '1;
      stage2 <= '1;
      stage3 <= '1;
    end else begin
      stage1 <= pin_raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // =====================================================
  // accept a new level only once two stages agree
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_level <= '1;
    end else begin
      pin_level <= (agree & stage3) | (~agree & pin_level);
    end
  end

endmodule : key_sync

//--- keypad_wake_interrupt_sva.sv
// port-level assertion checker for the keypad wake interrupt unit
`timescale 1ns/100ps
module keypad_wake_interrupt_sva
  import kwu_pkg::*;
#(
  parameter int NUM_KEYS = 8
) (
  // clock and reset
  input wire logic                clk_sys,
  input wire logic                rst,
  // apb
  input wire apb_req_type         apb_req,
  input wire apb_rsp_type         apb_rsp,
  // keypad pins
  input wire logic [NUM_KEYS-1:0] keypad_inputs,
  input wire logic [NUM_KEYS-1:0] pullup_en,
  input wire logic [NUM_KEYS-1:0] force_input,
  // processor side
  input wire logic                vector_fetch,
  input wire logic                break_state,
  input wire logic                cpu_request,
  input wire logic                wake_request,
  input wire logic [15:0]         vector_hi_addr,
  input wire logic [15:0]         vector_lo_addr,
  input wire logic                irq
);
  // ====================
  // helpers
  default clocking cb @(posedge clk_sys); endclocking
  // completed read of the status/control register
  wire rd_sc = apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == 12'h068;
  // ====================
  // assertions
  property p_pull_dir; disable iff (rst) pullup_en == force_input; endproperty
  a_pull_dir: assert property (p_pull_dir) else $error("pull-up and input override differ");
  property p_wake; disable iff (rst) wake_request == cpu_request; endproperty
  a_wake: assert property (p_wake) else $error("wake differs from request");
  property p_vec; disable iff (rst) vector_hi_addr == 16'hFFE0 && vector_lo_addr == 16'hFFE1; endproperty
  a_vec: assert property (p_vec) else $error("vector pair wrong");
  property p_reset; $fell(rst) |-> !cpu_request && pullup_en == '0 && !irq; endproperty
  a_reset: assert property (p_reset) else $error("outputs not clear after reset");
  property p_ready; disable iff (rst) apb_rsp.pready |=> !apb_rsp.pready; endproperty
  a_ready: assert property (p_ready) else $error("pready longer than one cycle");
  property p_wait; disable iff (rst) apb_req.psel && !apb_req.penable |=> !apb_rsp.pready ##1 apb_rsp.pready; endproperty
  a_wait: assert property (p_wait) else $error("answer not after one wait cycle");
  property p_idle; disable iff (rst) !apb_rsp.pready |-> apb_rsp.prdata == '0 && !apb_rsp.pslverr; endproperty
  a_idle: assert property (p_idle) else $error("response lines busy while idle");
  property p_strobe; disable iff (rst) rd_sc |-> !apb_rsp.prdata[2] && apb_rsp.prdata[31:4] == '0; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe or spare bits read nonzero");
  property p_mask; disable iff (rst) rd_sc && apb_rsp.prdata[1] |-> !cpu_request; endproperty
  a_mask: assert property (p_mask) else $error("masked request reached core");
  property p_slverr; disable iff (rst) apb_rsp.pready && apb_req.paddr[1:0] != 2'h0 |-> apb_rsp.pslverr; endproperty
  a_slverr: assert property (p_slverr) else $error("misaligned access accepted");
  property p_mapped; disable iff (rst) apb_rsp.pready && apb_req.paddr inside {12'h068, 12'h06C} |-> !apb_rsp.pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped register refused");
endmodule : keypad_wake_interrupt_sva

bind keypad_wake_interrupt keypad_wake_interrupt_sva #(.NUM_KEYS(NUM_KEYS)) u_sva (.clk_sys(clk_sys), .rst(rst),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .keypad_inputs(keypad_inputs), .pullup_en(pullup_en),
  .force_input(force_input), .vector_fetch(vector_fetch), .break_state(break_state), .cpu_request(cpu_request),
  .wake_request(wake_request), .vector_hi_addr(vector_hi_addr), .vector_lo_addr(vector_lo_addr), .irq(irq));

//--- keypad_switches.sv
// behavioural bank of eight key switches with per-pin pull-ups
`timescale 1ns/100ps
module keypad_switches (
  // clock
  input  wire logic       clk_sys,
  // key presses and pull-up controls
  input  wire logic [7:0] press,
  input  wire logic [7:0] pullup_en,
  output logic      [7:0] keypad_inputs
);
  logic [7:0] risen  = 8'h00; // pull-up has charged the pin
  logic       wobble = 1'h0;  // open pins wander, never a steady level
  // a pin charges one cycle after its pull-up turns on (load delay)
  always @(posedge clk_sys) begin
    risen  <= pullup_en;
    wobble <= !wobble;
  end
  // pressed key pulls low; open pin without pull-up toggles
  assign keypad_inputs = ~press & (risen | ({8{wobble}} ^ 8'hAA));
endmodule : keypad_switches

//--- keypad_wake_interrupt_tb.sv
// self-checking bench for the keypad wake interrupt unit
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module keypad_wake_interrupt_tb
  import kwu_pkg::*;
;
  // ====================
  // signals
  localparam logic [11:0] SC = 12'h068, EN = 12'h06C, BRK = 12'h070, EVS = 12'h074, EVM = 12'h078;
  logic        clk_sys = 1'h0;      // system clock
  logic        rst = 1'h1;          // sync reset
  apb_req_type apb_req = '0;        // bus request
  apb_rsp_type apb_rsp;             // bus answer
  logic [7:0]  press = 8'h00;       // keys held
  logic [7:0]  keys, pull, force_in;
  logic        vector_fetch = 1'h0;
  logic        break_state = 1'h0;
  logic        cpu_request, wake_request, irq;
  logic [15:0] vec_hi, vec_lo;
  logic [31:0] q;                   // last read data
  logic        q_err;               // last error flag
  int          num_errors = 0;
  int          num_checks = 0;
  int          k, j;
  keypad_wake_interrupt u_keypad_wake_interrupt (.clk_sys(clk_sys), .rst(rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .keypad_inputs(keys), .pullup_en(pull), .force_input(force_in),
    .vector_fetch(vector_fetch), .break_state(break_state), .cpu_request(cpu_request),
    .wake_request(wake_request), .vector_hi_addr(vec_hi), .vector_lo_addr(vec_lo), .irq(irq));
  keypad_switches u_keypad_switches (.clk_sys(clk_sys), .press(press), .pullup_en(pull), .keypad_inputs(keys));
  always #10 clk_sys = ~clk_sys;
  // ====================
  // helpers
  // expected status byte from {pending, mask, level}
  function automatic logic [7:0] sc(input logic [2:0] v);
    return {4'h0, v[2], 1'h0, v[1:0]};
  endfunction : sc
  // one apb transfer; holds the request until pready is sampled
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n = 0;
    apb_req <= '{1'h1, 1'h0, w, a, {24'h0, d}};
    @(posedge clk_sys);
    apb_req.penable <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (apb_rsp.pready !== 1'h1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, 1'h0, 1'h1);
    end
    q = apb_rsp.prdata;
    q_err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge clk_sys); // no second setup in this time step
  endtask : bus
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    `CHK(q, {24'h0, e})
  endtask : rd
  // pin changes pass the synchroniser within a fixed few cycles
  task automatic settle;
    repeat (8) @(posedge clk_sys);
  endtask : settle
  task automatic hit(input int n);
    press[n] <= 1'h1;
    settle();
  endtask : hit
  // v keeps the mode and mask bits that a software ack write carries
  task automatic ack_any(input logic [7:0] v);
    if ($urandom_range(1)) begin
      vector_fetch <= 1'h1;
      @(posedge clk_sys);
      vector_fetch <= 1'h0;
      @(posedge clk_sys);
    end else
      bus(1'h1, SC, v | 8'h04);
  endtask : ack_any
  task automatic stop_test;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    stop_test();
  end
  // ====================
  // main sequence
  initial begin
    k = $urandom(32'h90C3);
    repeat (20) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    rd(SC, 8'h00);
    rd(EN, 8'h00);
    `CHK({vec_hi, vec_lo}, 32'hFFE0FFE1)
    bus(1'h0, 12'h07C, 8'h00);
    `CHK(q_err, 1'h1)
    bus(1'h0, 12'h069, 8'h00);
    `CHK(q_err, 1'h1)
    // safe bring-up: mask, enable, wait for pull-ups, ack, unmask
    bus(1'h1, SC, 8'h02);
    bus(1'h1, EN, 8'hFF);
    settle();
    bus(1'h1, SC, 8'h06);
    rd(SC, sc(3'h2));
    bus(1'h1, SC, 8'h00);
    `CHK({pull, force_in}, 16'hFFFF)
    for (int i = 0; i < 4; i++) begin
      k = $urandom_range(7);
      j = (k + 1 + $urandom_range(6)) % 8;
      // edge mode: ack clears while held, second fall ignored
      hit(k);
      `CHK({cpu_request, wake_request}, 2'h3)
      rd(SC, sc(3'h4));
      bus(1'h1, SC, 8'h04);
      rd(SC, sc(3'h0));
      hit(j);
      rd(SC, sc(3'h0));
      press <= 8'h00;
      settle();
      hit(j);
      rd(SC, sc(3'h4));
      ack_any(8'h00);
      rd(SC, sc(3'h0));
      // level mode: both orders of release and ack
      press <= 8'h00;
      settle();
      bus(1'h1, SC, 8'h01);
      hit(k);
      ack_any(8'h01);
      rd(SC, sc(3'h5));
      press <= 8'h00;
      settle();
      rd(SC, sc(3'h1));
      hit(k);
      press <= 8'h00;
      settle();
      rd(SC, sc(3'h5));
      bus(1'h1, SC, 8'h05);
      rd(SC, sc(3'h1));
      // mask holds back the request, flag still visible
      bus(1'h1, SC, 8'h02);
      hit(k);
      `CHK(cpu_request, 1'h0)
      rd(SC, sc(3'h6));
      bus(1'h1, SC, 8'h00);
      settle();
      `CHK(cpu_request, 1'h1)
      bus(1'h1, SC, 8'h04);
      press <= 8'h00;
      // a disabled pin takes no part
      bus(1'h1, EN, ~(8'h01 << k));
      settle();
      `CHK(pull, ~(8'h01 << k))
      hit(k);
      rd(SC, sc(3'h0));
      press <= 8'h00;
      bus(1'h1, EN, 8'hFF);
      settle();
      bus(1'h1, SC, 8'h04);
    end
    // break state: ack ignored until clear is enabled, event raises irq
    bus(1'h1, EVM, 8'h02);
    rd(EVS, 8'h01);
    `CHK(irq, 1'h0)
    hit(k);
    break_state <= 1'h1;
    bus(1'h1, SC, 8'h04);
    rd(SC, sc(3'h4));
    `CHK(irq, 1'h1)
    bus(1'h1, BRK, 8'h01);
    bus(1'h1, SC, 8'h04);
    break_state <= 1'h0;
    rd(SC, sc(3'h0));
    bus(1'h1, EVS, 8'h03);
    rd(EVS, 8'h00);
    `CHK(irq, 1'h0)
    // reset with a key held low and a request latched
    press <= 8'h00;
    settle();
    hit(k);
    rst <= 1'h1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    rd(SC, 8'h00);
    rd(EN, 8'h00);
    `CHK(cpu_request, 1'h0)
    stop_test();
  end
endmodule : keypad_wake_interrupt_tb
